//--- design/eop_ctrl_regs.vh
// timing and layout constants for the extended output page dram controller
`ifndef EOP_CTRL_REGS_VH
`define EOP_CTRL_REGS_VH
`define EOP_CLK_MHZ          125
`define EOP_CLK_NS           8
`define EOP_WAKE_US          200
`define EOP_WAKE_CYC         ((`EOP_WAKE_US * 1000 + `EOP_CLK_NS - 1) / `EOP_CLK_NS)
`define EOP_WAKE_REFRESHES   8
`define EOP_REF_ROWS         512
`define EOP_REF_MS           8
`define EOP_REF_PERIOD_CYC   (`EOP_REF_MS * 1000000 / `EOP_CLK_NS)
`define EOP_REF_INTERVAL_CYC (`EOP_REF_PERIOD_CYC / `EOP_REF_ROWS)
`define EOP_ROW_W            9
`define EOP_COL_W            9
`define EOP_DATA_W           16
`define EOP_LANE_LO_MSB      7
`define EOP_LANE_HI_LSB      8
`define EOP_PHASE_CYC        4'h3
`define EOP_PRE_CYC          4'h6
`endif

//--- design/eop_phase_timer.v
// one-shot phase timer counting clock cycles down to a done pulse
`timescale 1ns/10ps
`default_nettype none
module eop_phase_timer (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       load,
    input  wire [3:0] count,
    output wire       done
);
    reg [3:0] cnt_q;
    reg       run_q;
    always @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
            run_q <= 1'b0;
        end else if (load) begin
            cnt_q <= count;
            run_q <= 1'b1;
        end else if (run_q) begin
            if (cnt_q == 4'h0)
                run_q <= 1'b0;
            else
                cnt_q <= cnt_q - 4'h1;
        end
    end
    // done must not look at load: the owner reloads on done
    assign done = run_q && (cnt_q == 4'h0);
endmodule // eop_phase_timer
`default_nettype wire

//--- design/eop_ctrl.v
// host controller driving an extended output page dram through its strobes
// Notes on behaviour
// - after reset wait 200 us, then eight refresh cycles before access.
// - after a missed refresh interval, repeat the eight wake-up refreshes.
// - raise row and column strobes for precharge before every new cycle.
// - never place write strobe between early and read-write windows.
// - output gate is never tied low so late writes stay possible.
// - raise output gate before driving data in late writes.
// - hidden refresh keeps write strobe high and output gate low after reads.
// - issue 512 refreshes per 8 ms.
// - column strobe falls before row strobe and stays low after it.
`timescale 1ns/10ps
`default_nettype none
`include "eop_ctrl_regs.vh"
module eop_ctrl #(
    parameter WAKE_CYC     = `EOP_WAKE_CYC,
    parameter REF_INTERVAL = `EOP_REF_INTERVAL_CYC
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        req_valid,
    output wire        req_ready,
    input  wire        req_write,
    input  wire [1:0]  req_byte_en,
    input  wire [17:0] req_addr,
    input  wire [15:0] req_wdata,
    output reg  [15:0] rsp_rdata,
    output reg         rsp_valid,
    output wire        init_done,
    input  wire        refresh_lost,
    output reg  [8:0]  mem_addr,
    output reg         row_strobe_n,
    output reg         lower_byte_column_strobe_n,
    output reg         upper_byte_column_strobe_n,
    output reg         write_strobe_n,
    output reg         output_gate_n,
    input  wire [15:0] mem_dq_in,
    output reg  [15:0] mem_dq_out,
    output reg         mem_dq_oe
);
    localparam ST_WAKE   = 4'h0;
    localparam ST_IDLE   = 4'h1;
    localparam ST_REF_C  = 4'h2;
    localparam ST_REF_R  = 4'h3;
    localparam ST_ROW    = 4'h4;
    localparam ST_COL    = 4'h5;
    localparam ST_READ   = 4'h6;
    localparam ST_PRE    = 4'h7;
    localparam ST_REF_H  = 4'h8;
    localparam integer WAKE_REFS_I = `EOP_WAKE_REFRESHES - 1;

    reg [3:0]  state_q;
    reg [17:0] wake_cnt_q;
    reg [3:0]  wake_refs_q;
    reg        awake_q;
    reg [10:0] ref_cnt_q;
    reg        ref_due_q;
    reg        wr_q;
    reg [1:0]  be_q;
    reg [8:0]  col_q;
    reg [15:0] wdata_q;
    reg [15:0] dq_s1_q;
    reg [15:0] dq_s2_q;
    reg [15:0] dq_s3_q;
    reg        tmr_load;
    reg [3:0]  tmr_count;
    wire       tmr_done;

    eop_phase_timer u_timer (
        .clk   (clk),
        .rst_n (rst_n),
        .load  (tmr_load),
        .count (tmr_count),
        .done  (tmr_done)
    );

    assign req_ready = (state_q == ST_IDLE) && awake_q && !ref_due_q && !refresh_lost;
    assign init_done = awake_q;

    // three-stage sampling of read data; only agreeing stages are used
    always @(posedge clk) begin
        if (!rst_n) begin
            dq_s1_q <= 16'h0000;
            dq_s2_q <= 16'h0000;
            dq_s3_q <= 16'h0000;
        end else begin
            dq_s1_q <= mem_dq_in;
            dq_s2_q <= dq_s1_q;
            dq_s3_q <= dq_s2_q;
        end
    end

    // periodic refresh request, 512 rows per 8 ms
    always @(posedge clk) begin
        if (!rst_n || !awake_q) begin
            ref_cnt_q <= 11'h000;
            ref_due_q <= 1'b0;
        end else if (ref_cnt_q == REF_INTERVAL[10:0] - 11'h001) begin
            // set wins over the clear, and the count never pauses, so no interval drifts
            ref_cnt_q <= 11'h000;
            ref_due_q <= 1'b1;
        end else begin
            ref_cnt_q <= ref_cnt_q + 11'h001;
            if (state_q == ST_REF_C)
                ref_due_q <= 1'b0;
        end
    end

    always @* begin
        tmr_load  = 1'b0;
        tmr_count = `EOP_PHASE_CYC;
        case (state_q)
            ST_IDLE: begin
                if (awake_q && (ref_due_q || (req_valid && req_ready)))
                    tmr_load = 1'b1;
                if (!awake_q && wake_cnt_q == 18'h00000)
                    tmr_load = 1'b1;
            end
            ST_WAKE: tmr_load = 1'b0;
            ST_REF_C, ST_REF_R, ST_ROW, ST_COL, ST_READ, ST_REF_H:
                tmr_load = tmr_done;
            ST_PRE: tmr_load = 1'b0;
            default: tmr_load = 1'b0;
        endcase
        if (state_q == ST_REF_R || state_q == ST_COL || state_q == ST_READ || state_q == ST_REF_H)
            tmr_count = `EOP_PRE_CYC;
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            state_q      <= ST_WAKE;
            wake_cnt_q   <= WAKE_CYC[17:0];
            wake_refs_q  <= 4'h0;
            awake_q      <= 1'b0;
            wr_q         <= 1'b0;
            be_q         <= 2'b00;
            col_q        <= 9'h000;
            wdata_q      <= 16'h0000;
            rsp_rdata    <= 16'h0000;
            rsp_valid    <= 1'b0;
            mem_addr     <= 9'h000;
            row_strobe_n <= 1'b1;
            lower_byte_column_strobe_n <= 1'b1;
            upper_byte_column_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            output_gate_n  <= 1'b1;
            mem_dq_out   <= 16'h0000;
            mem_dq_oe    <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            if (refresh_lost && state_q == ST_IDLE) begin
                awake_q     <= 1'b0;
                wake_refs_q <= 4'h0;
                wake_cnt_q  <= 18'h00000;
            end
            case (state_q)
                ST_WAKE: begin
                    if (wake_cnt_q == 18'h00000)
                        state_q <= ST_IDLE;
                    else
                        wake_cnt_q <= wake_cnt_q - 18'h00001;
                end
                ST_IDLE: begin
                    if (!awake_q && wake_cnt_q == 18'h00000) begin
                        state_q <= ST_REF_C;
                        lower_byte_column_strobe_n <= 1'b0;
                        upper_byte_column_strobe_n <= 1'b0;
                    end else if (awake_q && ref_due_q) begin
                        state_q <= ST_REF_C;
                        lower_byte_column_strobe_n <= 1'b0;
                        upper_byte_column_strobe_n <= 1'b0;
                    end else if (req_valid && req_ready) begin
                        state_q  <= ST_ROW;
                        wr_q     <= req_write;
                        be_q     <= req_byte_en;
                        col_q    <= req_addr[8:0];
                        wdata_q  <= req_wdata;
                        mem_addr <= req_addr[17:9];
                        row_strobe_n <= 1'b0;
                    end
                end
                ST_REF_C: if (tmr_done) begin
                    state_q <= ST_REF_R;
                    row_strobe_n <= 1'b0;
                end
                ST_REF_R: if (tmr_done) begin
                    state_q <= ST_PRE;
                    row_strobe_n <= 1'b1;
                    lower_byte_column_strobe_n <= 1'b1;
                    upper_byte_column_strobe_n <= 1'b1;
                    if (!awake_q) begin
                        wake_refs_q <= wake_refs_q + 4'h1;
                        if (wake_refs_q == WAKE_REFS_I[3:0])
                            awake_q <= 1'b1;
                    end
                end
                ST_ROW: if (tmr_done) begin
                    state_q  <= ST_COL;
                    mem_addr <= col_q;
                    if (wr_q) begin
                        write_strobe_n <= 1'b0;
                        mem_dq_out     <= wdata_q;
                        mem_dq_oe      <= 1'b1;
                        output_gate_n  <= 1'b1;
                    end else begin
                        output_gate_n  <= 1'b0;
                    end
                    lower_byte_column_strobe_n <= !be_q[0];
                    upper_byte_column_strobe_n <= !be_q[1];
                end
                ST_COL: if (tmr_done) begin
                    if (wr_q) begin
                        state_q <= ST_PRE;
                        row_strobe_n <= 1'b1;
                        lower_byte_column_strobe_n <= 1'b1;
                        upper_byte_column_strobe_n <= 1'b1;
                        write_strobe_n <= 1'b1;
                    end else begin
                        // sample only once second and third stages agree
                        if (dq_s2_q == dq_s3_q) begin
                            state_q <= ST_READ;
                            rsp_rdata[`EOP_LANE_LO_MSB:0] <= be_q[0] ? dq_s3_q[`EOP_LANE_LO_MSB:0] : 8'h00;
                            rsp_rdata[15:`EOP_LANE_HI_LSB] <= be_q[1] ? dq_s3_q[15:`EOP_LANE_HI_LSB] : 8'h00;
                            rsp_valid <= 1'b1;
                            // hidden refresh: keep column low, write high, gate low
                            row_strobe_n <= 1'b1;
                        end
                    end
                end
                ST_READ: if (tmr_done) begin
                    state_q <= ST_REF_H;
                    row_strobe_n <= 1'b0;
                end
                ST_REF_H: if (tmr_done) begin
                    state_q <= ST_PRE;
                    row_strobe_n <= 1'b1;
                    lower_byte_column_strobe_n <= 1'b1;
                    upper_byte_column_strobe_n <= 1'b1;
                    output_gate_n <= 1'b1;
                end
                ST_PRE: begin
                    mem_dq_oe     <= 1'b0;
                    output_gate_n <= 1'b1;
                    // strobes stay high for the whole precharge count
                    if (tmr_done)
                        state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule // eop_ctrl
`default_nettype wire

//--- verification/eop_ctrl_props.sv
// concurrent checks on the controller side of the dram strobe protocol
`timescale 1ns/10ps
`default_nettype none
module eop_ctrl_props #(
    parameter WAKE_CYC     = 25000,
    parameter REF_INTERVAL = 1953
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic init_done,
    input wire logic rsp_valid,
    input wire logic row_strobe_n,
    input wire logic lower_byte_column_strobe_n,
    input wire logic upper_byte_column_strobe_n,
    input wire logic write_strobe_n,
    input wire logic output_gate_n,
    input wire logic mem_dq_oe
);
    wire         col_lo = !lower_byte_column_strobe_n || !upper_byte_column_strobe_n;
    logic [31:0] wake_q;
    logic [31:0] gap_q;
    logic [7:0]  cref_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence cref_fall_s;
        $fell(row_strobe_n) && col_lo;
    endsequence
    sequence acc_fall_s;
        $fell(row_strobe_n) && !col_lo;
    endsequence
    always @(posedge clk) begin
        if (!rst_n) begin
            wake_q <= 32'h0;
            gap_q <= 32'h0;
            cref_q <= 8'h0;
        end else begin
            if (wake_q < WAKE_CYC)
                wake_q <= wake_q + 32'h1;
            // any column-first refresh restarts the gap, hidden ones included
            gap_q <= ($fell(row_strobe_n) && col_lo || !init_done) ? 32'h0 : gap_q + 32'h1;
            // a lost wake-up starts the count of wake refreshes again
            if ($fell(init_done))
                cref_q <= 8'h0;
            else if ($fell(row_strobe_n) && col_lo && cref_q != 8'hff)
                cref_q <= cref_q + 8'h1;
        end
    end
    wake_wait_a: assert property ($fell(row_strobe_n) |-> wake_q >= WAKE_CYC)
        else $error("row strobe fell before wake-up pause");
    wake_count_a: assert property ($rose(init_done) |-> cref_q >= 8'h8)
        else $error("ready before eight wake-up refreshes");
    cref_setup_a: assert property (cref_fall_s |-> $past(col_lo))
        else $error("column strobe not set up before row strobe");
    cref_hold_a: assert property (cref_fall_s |=> col_lo)
        else $error("column strobe not held after row strobe");
    precharge_a: assert property (acc_fall_s |-> $past(row_strobe_n, 2) && !$past(col_lo, 2))
        else $error("access without row and column precharge");
    dq_clash_a: assert property (mem_dq_oe |-> output_gate_n || !write_strobe_n)
        else $error("data driven while device may drive");
    hidden_read_a: assert property (rsp_valid |-> write_strobe_n && !output_gate_n)
        else $error("read end without gate low and write high");
    ref_gap_a: assert property (init_done |-> gap_q <= REF_INTERVAL + 64)
        else $error("refresh interval exceeded");
endmodule // eop_ctrl_props
`default_nettype wire

//--- verification/eop_dram_model.sv
// behavioural model of the dram device behind the controller
`timescale 1ns/10ps
`default_nettype none
module eop_dram_model (
    input  wire logic        row_strobe_n,
    input  wire logic        lower_byte_column_strobe_n,
    input  wire logic        upper_byte_column_strobe_n,
    input  wire logic        write_strobe_n,
    input  wire logic        output_gate_n,
    input  wire logic [8:0]  mem_addr,
    input  wire logic [15:0] dq_bus,
    output logic      [15:0] dq_dev,
    output int               ref_cnt
);
    logic [15:0] mem [0:262143];
    logic [8:0]  row_q;
    logic [17:0] a;
    logic [15:0] rd_q;
    realtime     col_t, we_t;
    wire         lc = lower_byte_column_strobe_n;
    wire         uc = upper_byte_column_strobe_n;
    wire         drv = !output_gate_n && write_strobe_n;
    // released lanes show the inverse so a stale sample cannot match
    assign dq_dev[7:0] = (drv && !lc) ? rd_q[7:0] : ~rd_q[7:0];
    assign dq_dev[15:8] = (drv && !uc) ? rd_q[15:8] : ~rd_q[15:8];
    initial ref_cnt = 0;
    always @(negedge row_strobe_n) begin
        #1;
        if (!lc || !uc)
            ref_cnt = ref_cnt + 1;
        else
            row_q = mem_addr;
    end
    always @(negedge lc or negedge uc) begin
        col_t = $realtime;
        #1;
        if (!row_strobe_n) begin
            a = {row_q, mem_addr};
            if (!write_strobe_n && !lc)
                mem[a][7:0] = dq_bus[7:0];
            if (!write_strobe_n && !uc)
                mem[a][15:8] = dq_bus[15:8];
            rd_q = mem[a];
        end
    end
    // late write: only when the column strobe fell strictly before the write strobe
    always @(negedge write_strobe_n) begin
        we_t = $realtime;
        #1;
        if (!row_strobe_n && output_gate_n && col_t < we_t) begin
            if (!lc)
                mem[a][7:0] = dq_bus[7:0];
            if (!uc)
                mem[a][15:8] = dq_bus[15:8];
        end
    end
endmodule // eop_dram_model
`default_nettype wire

//--- verification/eop_ctrl_tb_top.sv
// self-checking bench for the dram controller with a device model
`timescale 1ns/10ps
`default_nettype none
module eop_ctrl_tb_top;
    localparam WAKE = 20;
    localparam REFI = 200;
    typedef struct packed {
        logic        w;
        logic [1:0]  be;
        logic [17:0] a;
        logic [15:0] d;
        logic [15:0] e;
    } eop_row_t;
    logic        clk, rst_n, req_valid, req_write, refresh_lost;
    logic [1:0]  req_byte_en;
    logic [17:0] req_addr;
    logic [15:0] req_wdata, rd;
    wire         req_ready, rsp_valid, init_done, row_strobe_n, write_strobe_n, output_gate_n, mem_dq_oe;
    wire         lower_byte_column_strobe_n, upper_byte_column_strobe_n;
    wire  [8:0]  mem_addr;
    wire  [15:0] rsp_rdata, mem_dq_out, dq_dev, dq_bus;
    int          ref_cnt, n_fail, checks, r0;
    eop_row_t    rows [0:10] = '{
        '{1'h1, 2'h3, 18'h00123, 16'ha5c3, 16'h0}, '{1'h0, 2'h3, 18'h00123, 16'h0, 16'ha5c3},
        '{1'h1, 2'h1, 18'h00123, 16'h1234, 16'h0}, '{1'h0, 2'h3, 18'h00123, 16'h0, 16'ha534},
        '{1'h1, 2'h2, 18'h3ffff, 16'hbeef, 16'h0}, '{1'h1, 2'h1, 18'h3ffff, 16'h0011, 16'h0},
        '{1'h0, 2'h2, 18'h3ffff, 16'h0, 16'hbe00}, '{1'h0, 2'h1, 18'h3ffff, 16'h0, 16'h0011},
        '{1'h1, 2'h3, 18'h00000, 16'hffff, 16'h0}, '{1'h0, 2'h3, 18'h00000, 16'h0, 16'hffff},
        '{1'h0, 2'h3, 18'h00123, 16'h0, 16'ha534}};
    assign dq_bus = mem_dq_oe ? mem_dq_out : dq_dev;
    eop_ctrl #(.WAKE_CYC(WAKE), .REF_INTERVAL(REFI)) i_eop_ctrl (.clk, .rst_n, .req_valid, .req_ready,
        .req_write, .req_byte_en, .req_addr, .req_wdata, .rsp_rdata, .rsp_valid, .init_done, .refresh_lost,
        .mem_addr, .row_strobe_n, .lower_byte_column_strobe_n, .upper_byte_column_strobe_n, .write_strobe_n,
        .output_gate_n, .mem_dq_in(dq_bus), .mem_dq_out, .mem_dq_oe);
    eop_dram_model i_eop_dram_model (.row_strobe_n, .lower_byte_column_strobe_n, .upper_byte_column_strobe_n,
        .write_strobe_n, .output_gate_n, .mem_addr, .dq_bus, .dq_dev, .ref_cnt);
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // sel picks the flag: 0 ready, 1 read response, 2 wake-up done
    task waitfor(input int sel, input int lim);
        int n;
        n = 0;
        while (n < lim && (sel == 0 ? req_ready : sel == 1 ? rsp_valid : init_done) !== 1'b1) begin
            @(negedge clk);
            n++;
        end
        if (n >= lim) begin
            n_fail++;
            $display("ERROR wait %0d expected 1 seen 0", sel);
            results;
        end
    endtask
    task access(input eop_row_t r);
        @(negedge clk);
        waitfor(0, 5000);
        req_valid = 1'b1;
        req_write = r.w;
        req_byte_en = r.be;
        req_addr = r.a;
        req_wdata = r.d;
        @(negedge clk);
        req_valid = 1'b0;
        if (!r.w) begin
            waitfor(1, 200);
            rd = rsp_rdata;
        end
    endtask
    task wake;
        rst_n = 1'b0;
        repeat (20) @(negedge clk);
        r0 = ref_cnt;
        chk({row_strobe_n, lower_byte_column_strobe_n, upper_byte_column_strobe_n, write_strobe_n,
             output_gate_n, mem_dq_oe, init_done}, 7'h7c, "reset pins");
        rst_n = 1'b1;
        waitfor(2, 2000);
        chk(ref_cnt - r0, 8, "wake refreshes");
        $display("test wake finished");
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        {rst_n, req_valid, req_write, refresh_lost, req_byte_en, req_addr, req_wdata} = '0;
        n_fail = 0;
        checks = 0;
        wake;
        foreach (rows[i]) begin
            access(rows[i]);
            if (!rows[i].w)
                chk(rd, rows[i].e, "read data");
        end
        $display("test table finished");
        // the loss only acts in idle, so let the last read finish first
        waitfor(0, 2000);
        r0 = ref_cnt;
        refresh_lost = 1'b1;
        repeat (3) @(negedge clk);
        refresh_lost = 1'b0;
        chk(init_done, 1'b0, "wake redo flag");
        waitfor(0, 2000);
        chk(ref_cnt - r0 >= 8, 1, "redo refreshes");
        access(rows[3]);
        chk(rd, 16'ha534, "data after redo");
        $display("test refresh lost finished");
        r0 = ref_cnt;
        repeat (4 * REFI) @(negedge clk);
        chk((ref_cnt - r0) inside {[3:5]}, 1, "periodic refresh");
        $display("test periodic refresh finished");
        wake;
        access(rows[7]);
        chk(rd, 16'h0011, "data after reset");
        $display("test second reset finished");
        results;
    end
endmodule // eop_ctrl_tb_top
bind eop_ctrl eop_ctrl_props #(.WAKE_CYC(WAKE_CYC), .REF_INTERVAL(REF_INTERVAL)) i_eop_ctrl_props (.clk, .rst_n,
    .init_done, .rsp_valid, .row_strobe_n, .lower_byte_column_strobe_n, .upper_byte_column_strobe_n,
    .write_strobe_n, .output_gate_n, .mem_dq_oe);
`default_nettype wire
